// file: shared/gpio_ports_params.svh
// Constants for the three-port pin block: register offsets, fields, reset values.
`ifndef GPIO_PORTS_PARAMS_SVH
`define GPIO_PORTS_PARAMS_SVH

`define G_WIDTH              5
`define H_WIDTH              8
`define J_WIDTH              8

`define OFS_G_PINS           6'h00
`define OFS_G_LATCH          6'h04
`define OFS_G_DIR            6'h08
`define OFS_H_PINS           6'h0c
`define OFS_H_LATCH          6'h10
`define OFS_H_DIR            6'h14
`define OFS_J_PINS           6'h18
`define OFS_J_LATCH          6'h1c
`define OFS_J_DIR            6'h20
`define OFS_ANALOG_CFG       6'h24
`define OFS_MEMBUS_CFG       6'h28

`define RST_G_DIR            5'h1f
`define RST_H_DIR            8'hff
`define RST_J_DIR            8'hff
`define RST_LATCH            8'h00
`define RST_ANALOG_CFG       8'h00
`define RST_MEMBUS_CFG       8'h00

`define ANALOG_CFG_MASK      8'h3f
`define ANALOG_PCFG_LSB      0
`define ANALOG_PCFG_MSB      3
`define ANALOG_PCFG_ALL      4'h0
`define MEMBUS_CFG_MASK      8'hb3
`define MEMBUS_DISABLE_BIT   7
`define J_CHIP_ENABLE_BIT    5
`define H_LOW_LSB            0
`define H_LOW_MSB            3
`define H_HIGH_LSB           4
`define H_HIGH_MSB           7

`define AVS_ADDR_MIN_W       6
`define AVS_WAIT_CYCLES      1

`endif

// file: shared/gpio_ports_pkg.sv
// Types shared by the three-port pin block.
package gpio_ports_pkg;

    // Peripheral hold on the five-bit port: force output, force input, drive data
    typedef struct packed {
        logic [4:0] force_out;
        logic [4:0] force_in;
        logic [4:0] data;
    } periph_drive_t;

    // External-memory engine signals toward the pins
    typedef struct packed {
        logic       active;
        logic [3:0] addr_hi;
        logic [7:0] strobe;
    } mem_bus_t;

endpackage

// file: rtl/port_pin_cell.sv
// One group of bidirectional pins: direction, takeover, analog gating, read level.
`timescale 1ns/1ns
`include "gpio_ports_params.svh"

module port_pin_cell #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] latch_i,
    input  wire logic [WIDTH-1:0] dir_i,
    input  wire logic [WIDTH-1:0] take_i,
    input  wire logic [WIDTH-1:0] take_oe_i,
    input  wire logic [WIDTH-1:0] take_data_i,
    input  wire logic [WIDTH-1:0] force_in_i,
    input  wire logic [WIDTH-1:0] analog_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] pin_oe_o,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] oe_d;
    logic [WIDTH-1:0] out_d;

    if (WIDTH < 1 || WIDTH > 8)
    begin : g_chk
        $error("port_pin_cell: WIDTH must be 1 to 8");
    end

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (analog_i[i])
                oe_d[i] = 1'b0;
            else if (take_i[i])
                oe_d[i] = take_oe_i[i];          // see R13
            else if (force_in_i[i])
                oe_d[i] = 1'b0;                  // see R13
            else
                oe_d[i] = ~dir_i[i];             // see R1 see R2
            out_d[i] = take_i[i] ? take_data_i[i] : latch_i[i];
        end
    end

    // Analog pins read as zero on the digital side
    assign level_o = pin_i & ~analog_i;          // see R7

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pin_oe_o <= '0;
            pin_o    <= '0;
        end
        else
        begin
            pin_oe_o <= oe_d;
            pin_o    <= out_d;
        end
    end

    property dir_drive_p;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (~analog_i & ~take_i & ~force_in_i & ~dir_i) != '0
            |=> (pin_oe_o & $past(~analog_i & ~take_i & ~force_in_i & ~dir_i))
                == $past(~analog_i & ~take_i & ~force_in_i & ~dir_i);
    endproperty
    out_dir_drive_a: assert property (dir_drive_p) // see R1
        else $error("pin set to output by direction is not driven");

    analog_no_drive_a: assert property ( // see R7
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        analog_i != '0 |=> (pin_oe_o & $past(analog_i)) == '0)
        else $error("analog pin is driven");

endmodule

// file: rtl/gpio_ports_g_h_j.sv
// Five-bit, address-high/analog and memory-control pin ports with Avalon-MM registers.
//
// Notes on behaviour
// R1 - Address-high port: eight pins, direction 1 input tri-stated, 0 drives latch.
// R2 - Memory-control port: eight pins, same per-bit direction meaning.
// R3 - Address-high latch register reads and writes the latch, not pins.
// R4 - Memory-control latch register is mapped; reads return the latch value.
// R5 - Address-high upper four pins are analog or digital, chosen by analog config.
// R6 - Address-high lower four pins carry address bits 19:16 or digital I/O.
// R7 - After reset upper address-high pins are analog and read zero.
// R8 - After reset lower address-high pins belong to the memory bus address.
// R9 - Lower address-high pins sense Schmitt in I/O mode, TTL in bus mode.
// R10 - Memory-control port general I/O works only while memory bus is disabled; the code also allows it while the bus is enabled but not active.
// R11 - Active memory interface drives control strobes on memory-control pins.
// R12 - Chip-enable pin of memory-control port always stays general I/O.
// R13 - Enabled peripheral may force a shared pin to output or input.
// R14 - Peripheral forcing never changes the direction register contents.
// R15 - After reset all memory-control pins are digital inputs.
// R16 - Five-bit port bit 0 is I/O or timing channel three pin.
// R17 - Five-bit port bit 1 is I/O, serial transmit or serial sync clock.
// R18 - Five-bit port bit 2 is I/O, serial receive or serial sync data.
// R19 - Five-bit port bits 3 and 4 are I/O or timing channels four, five.
// R20 - Pin register reads pin levels; writes update the output latch.
// R21 - Five-bit port pins use Schmitt inputs and reset as inputs.
`timescale 1ns/1ns
`include "gpio_ports_params.svh"

module gpio_ports_g_h_j #(
    parameter int ADDR_W = 6
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic [ADDR_W-1:0]             avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [31:0]                   avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic      [31:0]                   avs_readdata_o,
    output logic                               avs_waitrequest_o,
    input  wire gpio_ports_pkg::periph_drive_t periph_i,
    input  wire gpio_ports_pkg::mem_bus_t      mem_bus_i,
    input  wire logic [`G_WIDTH-1:0]           g_pin_i,
    output logic      [`G_WIDTH-1:0]           g_pin_o,
    output logic      [`G_WIDTH-1:0]           g_pin_oe_o,
    input  wire logic [`H_WIDTH-1:0]           h_pin_i,
    output logic      [`H_WIDTH-1:0]           h_pin_o,
    output logic      [`H_WIDTH-1:0]           h_pin_oe_o,
    input  wire logic [`J_WIDTH-1:0]           j_pin_i,
    output logic      [`J_WIDTH-1:0]           j_pin_o,
    output logic      [`J_WIDTH-1:0]           j_pin_oe_o,
    output logic      [`G_WIDTH-1:0]           g_level_o,
    output logic                               h_low_ttl_sense_o
);

    if (ADDR_W < `AVS_ADDR_MIN_W)
    begin : g_chk
        $error("gpio_ports_g_h_j: ADDR_W too small for the register map");
    end

    logic [`G_WIDTH-1:0] g_latch_q;
    logic [`G_WIDTH-1:0] g_dir_q;
    logic [`H_WIDTH-1:0] h_latch_q;
    logic [`H_WIDTH-1:0] h_dir_q;
    logic [`J_WIDTH-1:0] j_latch_q;
    logic [`J_WIDTH-1:0] j_dir_q;
    logic [7:0]          analog_cfg_q;
    logic [7:0]          membus_cfg_q;
    logic                wait_q;
    logic [31:0]         rdata_q;

    logic [`G_WIDTH-1:0] g_level;
    logic [`H_WIDTH-1:0] h_level;
    logic [`J_WIDTH-1:0] j_level;
    logic                h_bus_mode;
    logic                j_bus_on;
    logic                upper_analog;
    logic [`H_WIDTH-1:0] h_take;
    logic [`H_WIDTH-1:0] h_analog;
    logic [`H_WIDTH-1:0] h_take_data;
    logic [`J_WIDTH-1:0] j_take;
    logic [`J_WIDTH-1:0] ce_mask;
    logic                wr_stb;
    logic                rd_take;
    logic [5:0]          addr;
    logic [7:0]          wdata;
    logic [7:0]          rd_mux;

    assign addr  = avs_address_i[5:0];
    assign wdata = avs_writedata_i[7:0];

    // Bus enabled when the disable bit is clear; reset leaves it enabled
    assign h_bus_mode   = ~membus_cfg_q[`MEMBUS_DISABLE_BIT];                 // see R8
    assign j_bus_on     = h_bus_mode & mem_bus_i.active;                      // see R10
    assign upper_analog = analog_cfg_q[`ANALOG_PCFG_MSB:`ANALOG_PCFG_LSB]
                          == `ANALOG_PCFG_ALL;                                // see R5

    always_comb
    begin
        h_take      = '0;
        h_analog    = '0;
        h_take_data = '0;
        h_take[`H_LOW_MSB:`H_LOW_LSB]      = {4{h_bus_mode}};                 // see R6
        h_take_data[`H_LOW_MSB:`H_LOW_LSB] = mem_bus_i.addr_hi;
        h_analog[`H_HIGH_MSB:`H_HIGH_LSB]  = {4{upper_analog}};               // see R7
    end

    always_comb
    begin
        ce_mask = '0;
        ce_mask[`J_CHIP_ENABLE_BIT] = 1'b1;
        j_take  = {`J_WIDTH{j_bus_on}} & ~ce_mask;                            // see R11 see R12
    end

    // Five-bit port: peripheral takes a pin to output, or holds it as input
    port_pin_cell #(
        .WIDTH       (`G_WIDTH)
    ) u_g_cell (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .latch_i     (g_latch_q),
        .dir_i       (g_dir_q),
        .take_i      (periph_i.force_out),                                    // see R13
        .take_oe_i   (periph_i.force_out),
        .take_data_i (periph_i.data),                                         // see R16 see R19
        .force_in_i  (periph_i.force_in),
        .analog_i    ('0),
        .pin_i       (g_pin_i),
        .pin_o       (g_pin_o),
        .pin_oe_o    (g_pin_oe_o),
        .level_o     (g_level)
    );

    port_pin_cell #(
        .WIDTH       (`H_WIDTH)
    ) u_h_cell (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .latch_i     (h_latch_q),
        .dir_i       (h_dir_q),
        .take_i      (h_take),
        .take_oe_i   ({`H_WIDTH{mem_bus_i.active}}),
        .take_data_i (h_take_data),
        .force_in_i  ('0),
        .analog_i    (h_analog),
        .pin_i       (h_pin_i),
        .pin_o       (h_pin_o),
        .pin_oe_o    (h_pin_oe_o),
        .level_o     (h_level)
    );

    port_pin_cell #(
        .WIDTH       (`J_WIDTH)
    ) u_j_cell (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .latch_i     (j_latch_q),
        .dir_i       (j_dir_q),
        .take_i      (j_take),
        .take_oe_i   ({`J_WIDTH{j_bus_on}}),
        .take_data_i (mem_bus_i.strobe),                                      // see R11
        .force_in_i  ('0),
        .analog_i    ('0),
        .pin_i       (j_pin_i),
        .pin_o       (j_pin_o),
        .pin_oe_o    (j_pin_oe_o),
        .level_o     (j_level)
    );

    // Receive and capture inputs for the peripherals, Schmitt sensed
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            g_level_o <= '0;
        else
            g_level_o <= g_level;                                             // see R17 see R18 see R21
    end

    // Lower address-high pins switch to TTL sensing in bus mode
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            h_low_ttl_sense_o <= 1'b1;
        else
            h_low_ttl_sense_o <= h_bus_mode;                                  // see R9
    end

    // Avalon slave: one wait cycle, access completes when waitrequest is low
    assign wr_stb  = avs_write_i & ~wait_q & avs_byteenable_i[0];
    assign rd_take = avs_read_i & wait_q;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            wait_q <= 1'b1;
        else if ((avs_read_i | avs_write_i) & wait_q)
            wait_q <= 1'b0;
        else
            wait_q <= 1'b1;
    end

    assign avs_waitrequest_o = wait_q;

    always_comb
    begin
        unique case (addr)
            `OFS_G_PINS:     rd_mux = {3'h0, g_level};                        // see R20
            `OFS_G_LATCH:    rd_mux = {3'h0, g_latch_q};
            `OFS_G_DIR:      rd_mux = {3'h0, g_dir_q};
            `OFS_H_PINS:     rd_mux = h_level;                                // see R7 see R20
            `OFS_H_LATCH:    rd_mux = h_latch_q;                              // see R3
            `OFS_H_DIR:      rd_mux = h_dir_q;
            `OFS_J_PINS:     rd_mux = j_level;                                // see R20
            `OFS_J_LATCH:    rd_mux = j_latch_q;                              // see R4
            `OFS_J_DIR:      rd_mux = j_dir_q;
            `OFS_ANALOG_CFG: rd_mux = analog_cfg_q;
            `OFS_MEMBUS_CFG: rd_mux = membus_cfg_q;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_q <= 32'h0000_0000;
        else if (rd_take)
            rdata_q <= {24'h00_0000, rd_mux};
    end

    assign avs_readdata_o = rdata_q;

    // Five-bit port latch and direction
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            g_latch_q <= `G_WIDTH'(`RST_LATCH);
            g_dir_q   <= `RST_G_DIR;                                          // see R21
        end
        else if (wr_stb)
        begin
            if (addr == `OFS_G_PINS || addr == `OFS_G_LATCH)
                g_latch_q <= wdata[`G_WIDTH-1:0];                             // see R20
            if (addr == `OFS_G_DIR)
                g_dir_q <= wdata[`G_WIDTH-1:0];                               // see R14
        end
    end

    // Address-high port latch and direction
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            h_latch_q <= `RST_LATCH;
            h_dir_q   <= `RST_H_DIR;
        end
        else if (wr_stb)
        begin
            if (addr == `OFS_H_PINS || addr == `OFS_H_LATCH)
                h_latch_q <= wdata;                                           // see R3
            if (addr == `OFS_H_DIR)
                h_dir_q <= wdata;
        end
    end

    // Memory-control port latch and direction
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            j_latch_q <= `RST_LATCH;
            j_dir_q   <= `RST_J_DIR;                                          // see R15
        end
        else if (wr_stb)
        begin
            if (addr == `OFS_J_PINS || addr == `OFS_J_LATCH)
                j_latch_q <= wdata;                                           // see R4
            if (addr == `OFS_J_DIR)
                j_dir_q <= wdata;
        end
    end

    // Pin-mode configuration; unimplemented bits stay zero
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            analog_cfg_q <= `RST_ANALOG_CFG;
            membus_cfg_q <= `RST_MEMBUS_CFG;
        end
        else if (wr_stb)
        begin
            if (addr == `OFS_ANALOG_CFG)
                analog_cfg_q <= wdata & `ANALOG_CFG_MASK;
            if (addr == `OFS_MEMBUS_CFG)
                membus_cfg_q <= wdata & `MEMBUS_CFG_MASK;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence req_open_s;
        (avs_read_i | avs_write_i) && avs_waitrequest_o;
    endsequence

    sequence answer_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    bus_answer_a: assert property (req_open_s |=> answer_s)
        else $error("bus access not answered after one wait cycle");

    latch_write_a: assert property ( // see R3
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && addr == `OFS_H_LATCH
            |=> h_latch_q == $past(avs_writedata_i[7:0]))
        else $error("address-high latch write lost");

    pin_write_a: assert property ( // see R20
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && addr == `OFS_J_PINS
            |=> j_latch_q == $past(avs_writedata_i[7:0]))
        else $error("pin register write did not reach latch");

    latch_read_a: assert property ( // see R4
        avs_read_i && avs_waitrequest_o && addr == `OFS_J_LATCH
            |=> avs_readdata_o == {24'h00_0000, $past(j_latch_q)})
        else $error("latch read did not return the latch");

    dir_keep_a: assert property ( // see R14
        !(avs_write_i && addr == `OFS_G_DIR) |=> $stable(g_dir_q))
        else $error("direction register changed without a write");

    analog_read_a: assert property ( // see R7
        upper_analog && avs_read_i && avs_waitrequest_o && addr == `OFS_H_PINS
            |=> avs_readdata_o[`H_HIGH_MSB:`H_HIGH_LSB] == 4'h0)
        else $error("analog pins read nonzero");

    chip_enable_a: assert property ( // see R12
        j_bus_on && !j_dir_q[`J_CHIP_ENABLE_BIT]
            |=> j_pin_oe_o[`J_CHIP_ENABLE_BIT] && j_pin_o[`J_CHIP_ENABLE_BIT]
                == $past(j_latch_q[`J_CHIP_ENABLE_BIT]))
        else $error("chip-enable pin left general I/O");

    strobe_drive_a: assert property ( // see R11
        j_bus_on |=> (j_pin_oe_o | ce_mask) == 8'hff
            && (j_pin_o & ~ce_mask) == ($past(mem_bus_i.strobe) & ~ce_mask))
        else $error("memory strobes not on pins");

    addr_drive_a: assert property ( // see R6
        h_bus_mode && mem_bus_i.active
            |=> h_pin_oe_o[`H_LOW_MSB:`H_LOW_LSB] == 4'hf
                && h_pin_o[`H_LOW_MSB:`H_LOW_LSB] == $past(mem_bus_i.addr_hi))
        else $error("high address bits not on pins");

    force_out_a: assert property ( // see R13
        periph_i.force_out[0] |=> g_pin_oe_o[0] && g_pin_o[0] == $past(periph_i.data[0]))
        else $error("peripheral output not forced on pin");

    force_in_a: assert property ( // see R13
        periph_i.force_in[2] && !periph_i.force_out[2] && !g_dir_q[2] |=> !g_pin_oe_o[2])
        else $error("peripheral input force ignored");

    io_idle_a: assert property ( // see R10
        !j_bus_on && j_dir_q == 8'hff |=> j_pin_oe_o == 8'h00)
        else $error("memory-control pin driven while input");

endmodule

// file: verification/pin_world.sv
// Far-side circuitry on one group of pins: resolves drivers into the input level.
`timescale 1ns/1ns

module pin_world #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] drv_i,
    input  wire logic [WIDTH-1:0] oe_i,
    input  wire logic [WIDTH-1:0] ext_i,
    input  wire logic [WIDTH-1:0] ext_en_i,
    output logic      [WIDTH-1:0] pin_o
);
    logic [WIDTH-1:0] float_q;

    // A line nobody drives toggles, so a stale value never looks valid
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            float_q <= '0;
        else
            float_q <= ~float_q;
    end

    // Driver high-impedance unless enabled
    assign pin_o = (ext_en_i & ext_i) | (~ext_en_i & oe_i & drv_i)
                 | (~ext_en_i & ~oe_i & float_q);
endmodule

// file: verification/tb.sv
// Register and pin tests for the three-port pin block.
`timescale 1ns/1ns
`include "gpio_ports_params.svh"

module tb;
    logic                          sys_clk_i;
    logic                          sys_rst_i;
    logic [5:0]                    addr;
    logic                          rd;
    logic                          wr;
    logic [31:0]                   wdata;
    logic [3:0]                    be;
    logic [31:0]                   rdata;
    logic                          waitreq;
    gpio_ports_pkg::periph_drive_t periph;
    gpio_ports_pkg::mem_bus_t      mem_bus;
    logic [4:0]                    g_in, g_out, g_oe, g_level, g_ext, g_ext_en;
    logic [7:0]                    h_in, h_out, h_oe, h_ext, h_ext_en;
    logic [7:0]                    j_in, j_out, j_oe, j_ext, j_ext_en;
    logic                          ttl;
    int                            n_fail;
    int                            samples_checked;

    gpio_ports_g_h_j #(.ADDR_W(6)) dut_u (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .periph_i(periph), .mem_bus_i(mem_bus), .g_pin_i(g_in), .g_pin_o(g_out),
        .g_pin_oe_o(g_oe), .h_pin_i(h_in), .h_pin_o(h_out), .h_pin_oe_o(h_oe),
        .j_pin_i(j_in), .j_pin_o(j_out), .j_pin_oe_o(j_oe), .g_level_o(g_level),
        .h_low_ttl_sense_o(ttl));

    pin_world #(.WIDTH(5)) g_world_u (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .drv_i(g_out),
        .oe_i(g_oe), .ext_i(g_ext), .ext_en_i(g_ext_en), .pin_o(g_in));
    pin_world #(.WIDTH(8)) h_world_u (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .drv_i(h_out),
        .oe_i(h_oe), .ext_i(h_ext), .ext_en_i(h_ext_en), .pin_o(h_in));
    pin_world #(.WIDTH(8)) j_world_u (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .drv_i(j_out),
        .oe_i(j_oe), .ext_i(j_ext), .ext_en_i(j_ext_en), .pin_o(j_in));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pchk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: pin value %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic access(input logic [5:0] a, input logic w, input logic [7:0] d,
                          input logic [3:0] b, output logic [31:0] q);
        int n;
        @(posedge sys_clk_i);
        addr  <= a;
        rd    <= !w;
        wr    <= w;
        wdata <= {24'h0, d};
        be    <= b;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0)
        begin
            n_fail++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wreg(input logic [5:0] a, input logic [7:0] d, input logic [3:0] b = 4'hf);
        logic [31:0] q;
        access(a, 1'b1, d, b, q);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [31:0] q;
        access(a, 1'b0, 8'h00, 4'hf, q);
        cmp(q, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (3) @(negedge sys_clk_i);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        test_done();
    end

    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        sys_rst_i = 1'b1;
        {addr, rd, wr, wdata, be} = '0;
        periph = '0;
        mem_bus = '0;
        {g_ext, g_ext_en, h_ext, h_ext_en, j_ext, j_ext_en} = '0;
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        settle();
        pchk({3'h0, g_oe}, 8'h00);
        pchk(j_oe, 8'h00);
        pchk({4'h0, h_oe[7:4]}, 8'h00);
        pchk({7'h0, ttl}, 8'h01);
        rchk(`OFS_G_DIR, 8'h1f);
        rchk(`OFS_H_DIR, 8'hff);
        rchk(`OFS_J_DIR, 8'hff);
        rchk(`OFS_ANALOG_CFG, 8'h00);
        rchk(`OFS_MEMBUS_CFG, 8'h00);
        @(posedge sys_clk_i);
        h_ext <= 8'hff;
        h_ext_en <= 8'hff;
        settle();
        rchk(`OFS_H_PINS, 8'h0f);
        h_ext_en <= 8'h00;
        wreg(`OFS_MEMBUS_CFG, 8'h80);
        wreg(`OFS_ANALOG_CFG, 8'h0f);
        settle();
        pchk({7'h0, ttl}, 8'h00);
        wreg(`OFS_H_LATCH, 8'ha5);
        wreg(`OFS_H_DIR, 8'h00);
        settle();
        pchk(h_oe, 8'hff);
        pchk(h_out, 8'ha5);
        rchk(`OFS_H_LATCH, 8'ha5);
        rchk(`OFS_H_PINS, 8'ha5);
        wreg(`OFS_H_LATCH, 8'h5a, 4'h0);
        rchk(`OFS_H_LATCH, 8'ha5);
        wreg(`OFS_H_DIR, 8'hf0);
        settle();
        pchk(h_oe, 8'h0f);
        wreg(`OFS_H_PINS, 8'h3c);
        rchk(`OFS_H_LATCH, 8'h3c);
        wreg(`OFS_J_LATCH, 8'h3c);
        wreg(`OFS_J_DIR, 8'h00);
        settle();
        pchk(j_oe, 8'hff);
        pchk(j_out, 8'h3c);
        rchk(`OFS_J_LATCH, 8'h3c);
        mem_bus <= '{active: 1'b1, addr_hi: 4'h9, strobe: 8'h55};
        wreg(`OFS_MEMBUS_CFG, 8'h00);
        settle();
        pchk(j_out, 8'h75);
        pchk({4'h0, h_out[3:0]}, 8'h09);
        pchk({4'h0, h_oe[3:0]}, 8'h0f);
        pchk({7'h0, ttl}, 8'h01);
        wreg(`OFS_J_DIR, 8'hff);
        settle();
        pchk(j_oe, 8'hdf);
        mem_bus.active <= 1'b0;
        settle();
        pchk(j_oe, 8'h00);
        wreg(`OFS_J_PINS, 8'hc3);
        rchk(`OFS_J_LATCH, 8'hc3);
        j_ext <= 8'h96;
        j_ext_en <= 8'hff;
        settle();
        rchk(`OFS_J_PINS, 8'h96);
        wreg(`OFS_G_LATCH, 8'h15);
        wreg(`OFS_G_DIR, 8'h00);
        settle();
        pchk({3'h0, g_out}, 8'h15);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge sys_clk_i);
            periph <= {5'(1 << i), 5'h00, 5'h0a};
            settle();
            pchk({3'h0, g_out}, {3'h0, 5'h15 ^ 5'(1 << i)});
            @(posedge sys_clk_i);
            periph <= {5'h00, 5'(1 << i), 5'h00};
            settle();
            pchk({3'h0, g_oe}, {3'h0, 5'h1f & ~5'(1 << i)});
        end
        periph <= '0;
        rchk(`OFS_G_DIR, 8'h00);
        wreg(`OFS_G_DIR, 8'h1f);
        g_ext <= 5'h0a;
        g_ext_en <= 5'h1f;
        settle();
        pchk({3'h0, g_level}, 8'h0a);
        rchk(`OFS_G_PINS, 8'h0a);
        wreg(6'h3c, 8'hff);
        rchk(6'h3c, 8'h00);
        wreg(`OFS_ANALOG_CFG, 8'hff);
        rchk(`OFS_ANALOG_CFG, `ANALOG_CFG_MASK);
        wreg(`OFS_MEMBUS_CFG, 8'hff);
        rchk(`OFS_MEMBUS_CFG, `MEMBUS_CFG_MASK);
        test_done();
    end
endmodule
